//--- lcfs_pkg.sv
package lcfs_pkg;

   // clock and timing
   localparam int unsigned CLK_PERIOD_NS = 4;          // 250 mhz system clock
   localparam int unsigned RAIL_STEP_US  = 10000;      // gap between rail steps
   localparam int unsigned RAIL_STEP_CYC =
      RAIL_STEP_US * 1000 / CLK_PERIOD_NS;              // cycles per rail step
   localparam int unsigned STEP_CNT_W    = 22;         // step counter width

   // led current codes
   localparam int unsigned CODE_W        = 10;         // per-channel code width
   localparam logic [9:0]  CODE_OFF      = 10'h000;    // no channel selected
   localparam logic [9:0]  CODE_272MA    = 10'h100;    // trimmed 272 ma point
   localparam logic [9:0]  CODE_FULL     = 10'h3FF;    // full scale

   // color select encodings
   localparam logic [1:0]  SEL_NONE      = 2'h0;
   localparam logic [1:0]  SEL_CH_A      = 2'h1;
   localparam logic [1:0]  SEL_CH_B      = 2'h2;
   localparam logic [1:0]  SEL_CH_C      = 2'h3;

   // measurement mux one-hot positions
   localparam int unsigned MUX_SENSOR_TWO = 0;
   localparam int unsigned MUX_LED_RAIL   = 1;
   localparam int unsigned MUX_ANALOG_SUP = 2;
   localparam int unsigned MUX_SENSOR_ONE = 3;
   localparam int unsigned MUX_SENSE_NODE = 4;
   localparam int unsigned MUX_SWITCH_A   = 5;
   localparam int unsigned MUX_SWITCH_B   = 6;
   localparam int unsigned MUX_SWITCH_C   = 7;
   localparam logic [7:0]  MUX_ONE        = 8'h01;

   // number of fault and event sources
   localparam int unsigned NUM_EVT        = 7;

   // fault comparators and interrupt flags share one layout
   typedef struct packed {
      logic hot;              // die hot warning
      logic thermal_shutdown; // thermal shutdown
      logic low_battery;      // low battery
      logic undervoltage;     // undervoltage lockout
      logic mirror_fault;     // mirror regulator fault
      logic aux_power_fail;   // auxiliary rail power-good lost
      logic led_overvoltage;  // led rail overvoltage
   } lcfs_evt_t;

   // rail sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_OFF  = 4'b0001,
      ST_UP   = 4'b0010,
      ST_ACT  = 4'b0100,
      ST_DOWN = 4'b1000
   } lcfs_state_t;

endpackage : lcfs_pkg

//--- lcfs_supervisor.sv
`timescale 1ns/100ps
module lcfs_supervisor
   import lcfs_pkg::*;
#(
   parameter int unsigned STEP_CYCLES = RAIL_STEP_CYC  // rail step length
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // display controller side
   input  wire logic [1:0]        color_select,
   input  wire logic              projector_on,
   // configuration bits
   input  wire logic [9:0]        ch_a_current_code,
   input  wire logic [9:0]        ch_b_current_code,
   input  wire logic [9:0]        ch_c_current_code,
   input  wire logic [2:0]        transient_limit_value,
   input  wire logic [2:0]        transient_limit_sel,
   input  wire logic [2:0]        measure_input_select,
   input  wire logic              measure_cal_disable,
   input  wire logic              flag_read,
   // analog comparators, asynchronous
   input  wire lcfs_evt_t         fault_cmp,
   // analog control outputs
   output logic [9:0]             dac_code,
   output logic                   limit_active,
   output logic [2:0]             limit_value,
   output logic [7:0]             measure_mux,
   output logic                   measure_cal_dis_out,
   output logic                   mirror_rails_en,
   output logic                   led_driver_en,
   output logic                   standby,
   // status
   output logic                   mirror_supply_enable,
   output lcfs_evt_t              flags,
   output logic                   interrupt_out_n_o,
   output logic                   interrupt_out_n_oe
);

   logic [NUM_EVT-1:0]    sync1_q;     // first synchroniser stage
   logic [NUM_EVT-1:0]    sync2_q;     // second synchroniser stage
   lcfs_evt_t             evt;         // synchronised comparator levels
   lcfs_evt_t             flags_q;     // sticky interrupt flags
   lcfs_state_t           state_q;     // rail sequencer state
   logic [STEP_CNT_W-1:0] step_cnt_q;  // rail step timer
   logic                  mir_en_q;    // mirror supply enable bit
   logic                  seen_low_q;  // on pin low in the previous cycle
   logic                  rearm;       // completed on toggle
   logic                  run;         // conditions for rails to be up
   logic                  stop_now;    // faults that drop rails at once
   logic                  step_done;   // step timer expired

   // two-flop synchroniser per comparator
   for (genvar i = 0; i < NUM_EVT; i++) begin : g_sync
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            sync1_q[i] <= 1'b0;
            sync2_q[i] <= 1'b0;
         end else begin
            sync1_q[i] <= fault_cmp[i];
            sync2_q[i] <= sync1_q[i];
         end
      end
   end
   assign evt = lcfs_evt_t'(sync2_q);

   // current code routing by color
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dac_code <= CODE_OFF;
      end else begin
         unique case (color_select)
            SEL_CH_A: dac_code <= ch_a_current_code;
            SEL_CH_B: dac_code <= ch_b_current_code;
            SEL_CH_C: dac_code <= ch_c_current_code;
            SEL_NONE: dac_code <= CODE_OFF;
         endcase
      end
   end

   // transient limit applies on selected switches only
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         limit_active <= 1'b0;
         limit_value  <= 3'h0;
      end else begin
         limit_value  <= transient_limit_value;
         limit_active <= (color_select != SEL_NONE) &&
                         transient_limit_sel[color_select - 2'h1];
      end
   end

   // measurement mux decode
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         measure_mux         <= MUX_ONE;
         measure_cal_dis_out <= 1'b0;
      end else begin
         measure_mux         <= MUX_ONE << measure_input_select;
         measure_cal_dis_out <= measure_cal_disable;
      end
   end

   // sticky flags: a set in the read cycle wins over the clear
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         flags_q <= '0;
      end else if (flag_read) begin
         flags_q <= evt;
      end else begin
         flags_q <= flags_q | evt;
      end
   end
   assign flags = flags_q;

   // open-drain interrupt, low while any flag stands
   assign interrupt_out_n_o  = 1'b0;
   assign interrupt_out_n_oe = |flags_q;

   // on-pin toggle detector
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         seen_low_q <= 1'b0;
      end else if (!projector_on) begin
         seen_low_q <= 1'b1;
      end else begin
         seen_low_q <= 1'b0;
      end
   end
   assign rearm = projector_on && seen_low_q;

   // mirror supply enable bit, defaults to one
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mir_en_q <= 1'b1;
      end else if (evt.undervoltage || evt.mirror_fault) begin
         mir_en_q <= 1'b0;
      end else if (rearm) begin
         mir_en_q <= 1'b1;
      end
   end
   assign mirror_supply_enable = mir_en_q;

   // thermal shutdown leaves the enable bit alone
   assign run = projector_on && mir_en_q && !evt.thermal_shutdown &&
                !evt.undervoltage;
   assign stop_now  = evt.thermal_shutdown || evt.mirror_fault;
   assign step_done = (step_cnt_q == STEP_CNT_W'(STEP_CYCLES - 1));

   // rail sequencer
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= ST_OFF;
      end else begin
         unique case (state_q)
            ST_OFF: begin
               if (run) state_q <= ST_UP;
            end
            ST_UP: begin
               if (stop_now) state_q <= ST_OFF;
               else if (!run) state_q <= ST_DOWN;
               else if (step_done) state_q <= ST_ACT;
            end
            ST_ACT: begin
               if (stop_now) state_q <= ST_OFF;
               else if (!run) state_q <= ST_DOWN;
            end
            ST_DOWN: begin
               if (stop_now || step_done) state_q <= ST_OFF;
            end
         endcase
      end
   end

   // step timer restarts on every state change
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         step_cnt_q <= '0;
      end else if ((state_q == ST_UP && run && !stop_now && !step_done) ||
                   (state_q == ST_DOWN && !stop_now && !step_done)) begin
         step_cnt_q <= step_cnt_q + STEP_CNT_W'(1);
      end else begin
         step_cnt_q <= '0;
      end
   end

   // rail enables
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mirror_rails_en <= 1'b0;
         led_driver_en   <= 1'b0;
         standby         <= 1'b0;
      end else begin
         mirror_rails_en <= (state_q != ST_OFF) && !stop_now;
         led_driver_en   <= (state_q == ST_ACT) && run && !stop_now &&
                            !evt.aux_power_fail;
         standby         <= projector_on && (state_q == ST_OFF);
      end
   end

   // checks
   chk_dac_route: assert property (
      @(posedge sys_clk) disable iff (rst)
      color_select == SEL_CH_B |=> dac_code == $past(ch_b_current_code))
      else $error("dac code not from channel b");
   chk_thermal_rails: assert property (
      @(posedge sys_clk) disable iff (rst)
      evt.thermal_shutdown |=> !mirror_rails_en && !led_driver_en)
      else $error("rails on during thermal shutdown");
   chk_thermal_keep: assert property (
      @(posedge sys_clk) disable iff (rst)
      evt.thermal_shutdown && !evt.undervoltage && !evt.mirror_fault
      |=> mir_en_q == $past(mir_en_q))
      else $error("thermal event changed enable");
   chk_mirror_clr: assert property (
      @(posedge sys_clk) disable iff (rst)
      evt.mirror_fault |=> !mir_en_q ##1 !led_driver_en)
      else $error("mirror fault kept enable");
   chk_no_restart: assert property (
      @(posedge sys_clk) disable iff (rst)
      $rose(mir_en_q) |-> $past(seen_low_q) && $past(projector_on))
      else $error("enable set without toggle");
   chk_flag_set: assert property (
      @(posedge sys_clk) disable iff (rst)
      evt.led_overvoltage |=> flags_q.led_overvoltage && interrupt_out_n_oe)
      else $error("event flag lost");
   chk_read_clr: assert property (
      @(posedge sys_clk) disable iff (rst)
      flag_read && evt == '0 |=> flags_q == '0 && !interrupt_out_n_oe)
      else $error("read did not clear flags");
   chk_mux_dec: assert property (
      @(posedge sys_clk) disable iff (rst)
      measure_input_select == 3'h4 |=> measure_mux[MUX_SENSE_NODE] &&
      $onehot(measure_mux))
      else $error("mux decode wrong");
   chk_bat_run: assert property (
      @(posedge sys_clk) disable iff (rst)
      state_q == ST_ACT && run && !stop_now && !evt.aux_power_fail
      |=> led_driver_en)
      else $error("led off while running");

endmodule : lcfs_supervisor

//--- lcfs_ctrl_model.sv
`timescale 1ns/100ps
// display controller stand-in: colour select and on pin
module lcfs_ctrl_model
   import lcfs_pkg::*;
(
   // clock
   input  wire logic       sys_clk,
   // requests from the bench
   input  wire logic [1:0] want_sel,
   input  wire logic       want_on,
   // pins toward the supervisor
   output logic      [1:0] color_select,
   output logic            projector_on
);
   logic [1:0] sel_q; // request captured mid-cycle
   logic       on_q;  // on pin request captured mid-cycle
   // capture on the rising edge, away from the bench's falling-edge writes
   always @(posedge sys_clk) begin
      sel_q <= want_sel;
      on_q  <= want_on;
   end
   // launch on the falling edge so the design samples settled pins
   always @(negedge sys_clk) begin
      color_select <= sel_q;
      projector_on <= on_q;
   end
endmodule : lcfs_ctrl_model

//--- testbench.sv
`timescale 1ns/100ps
module testbench
   import lcfs_pkg::*;
;
   typedef struct packed {
      logic [1:0] sel;
      logic [2:0] lsel;
      logic [9:0] dac;
      logic       act;
   } lcfs_row_t;
   logic       sys_clk, rst, want_on, flag_read, cal, rails, led, stby;
   logic       act, cal_o, mse, int_o, int_oe, projector_on;
   logic [1:0] want_sel, color_select;
   logic [2:0] lim_val, lim_sel, msel, lim_o;
   logic [9:0] dac;
   logic [7:0] mux;
   lcfs_evt_t  fault_cmp, flags;
   int         n_errors, samples_checked;
   int         wb[3] = '{6, 4, 0};
   // select, limit selects, expected code and limiting
   lcfs_row_t  rows[8] = '{
      '{SEL_CH_A, 3'b001, CODE_272MA, 1'b1},
      '{SEL_CH_B, 3'b001, CODE_FULL, 1'b0},
      '{SEL_CH_C, 3'b100, 10'h001, 1'b1},
      '{SEL_NONE, 3'b111, CODE_OFF, 1'b0},
      '{SEL_CH_A, 3'b110, CODE_272MA, 1'b0},
      '{SEL_CH_B, 3'b010, CODE_FULL, 1'b1},
      '{SEL_CH_C, 3'b011, 10'h001, 1'b0},
      '{SEL_CH_A, 3'b001, CODE_272MA, 1'b1}};

   lcfs_ctrl_model ctl (.sys_clk(sys_clk), .want_sel(want_sel),
      .want_on(want_on), .color_select(color_select),
      .projector_on(projector_on));
   lcfs_supervisor #(.STEP_CYCLES(8)) uut (.sys_clk(sys_clk), .rst(rst),
      .color_select(color_select), .projector_on(projector_on),
      .ch_a_current_code(CODE_272MA), .ch_b_current_code(CODE_FULL),
      .ch_c_current_code(10'h001), .transient_limit_value(lim_val),
      .transient_limit_sel(lim_sel), .measure_input_select(msel),
      .measure_cal_disable(cal), .flag_read(flag_read),
      .fault_cmp(fault_cmp), .dac_code(dac), .limit_active(act),
      .limit_value(lim_o), .measure_mux(mux), .measure_cal_dis_out(cal_o),
      .mirror_rails_en(rails), .led_driver_en(led), .standby(stby),
      .mirror_supply_enable(mse), .flags(flags),
      .interrupt_out_n_o(int_o), .interrupt_out_n_oe(int_oe));

   // free-running 250 mhz clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task conclude;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   task chk_v(input string nm, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask : chk_v
   task chk_b(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s exp %b got %b", nm, e, g);
      end
   endtask : chk_b
   task tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : tick
   // bounded wait on the led driver enable
   task wait_led(input logic v);
      int k;
      k = 0;
      while (led !== v && k < 60) begin
         tick(1);
         k++;
      end
      if (led !== v) begin
         n_errors++;
         $display("mismatch led_driver_en exp %b got %b", v, led);
         conclude();
      end
   endtask : wait_led
   task read_flags;
      flag_read = 1'b1;
      tick(1);
      flag_read = 1'b0;
      tick(2);
   endtask : read_flags
   // low then high on the on pin
   task toggle_on;
      want_on = 1'b0;
      tick(3);
      want_on = 1'b1;
   endtask : toggle_on

   initial begin
      {rst, want_on, flag_read, cal, want_sel, lim_val, lim_sel, msel} = '0;
      rst = 1'b1;
      fault_cmp = '0;
      n_errors = 0;
      samples_checked = 0;
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk) rst = 1'b0;
      chk_v("flags", 16'h0000, flags);
      chk_b("mirror_supply_enable", 1'b1, mse);
      chk_v("measure_mux", 16'h0001, mux);
      $display("reset test done");
      // routing table
      foreach (rows[i]) begin
         want_sel = rows[i].sel;
         lim_sel = rows[i].lsel;
         msel = 3'(i);
         lim_val = 3'(7 - i);
         cal = i[0];
         tick(3);
         chk_v("dac_code", 16'(rows[i].dac), 16'(dac));
         chk_b("limit_active", rows[i].act, act);
         chk_v("limit_value", 16'(7 - i), 16'(lim_o));
         chk_v("measure_mux", 16'(MUX_ONE << i), 16'(mux));
         chk_b("measure_cal_dis_out", i[0], cal_o);
      end
      $display("routing test done");
      want_on = 1'b1;
      wait_led(1'b1);
      chk_b("mirror_rails_en", 1'b1, rails);
      // warnings: hot, low battery, overvoltage keep the rails up
      foreach (wb[j]) begin
         fault_cmp[wb[j]] = 1'b1;
         tick(1);
         chk_v("flags", 16'h0000, flags);
         tick(3);
         chk_v("flags", 16'(8'h01 << wb[j]), flags);
         chk_b("interrupt_oe", 1'b1, int_oe);
         chk_b("interrupt_out_n_o", 1'b0, int_o);
         chk_b("led_driver_en", 1'b1, led);
         read_flags();
         chk_v("flags", 16'(8'h01 << wb[j]), flags);
         fault_cmp[wb[j]] = 1'b0;
         tick(3);
         read_flags();
         chk_v("flags", 16'h0000, flags);
         chk_b("interrupt_oe", 1'b0, int_oe);
      end
      $display("warning test done");
      fault_cmp.aux_power_fail = 1'b1;
      tick(4);
      chk_b("aux_flag", 1'b1, flags.aux_power_fail);
      wait_led(1'b0);
      fault_cmp.aux_power_fail = 1'b0;
      wait_led(1'b1);
      read_flags();
      fault_cmp.thermal_shutdown = 1'b1;
      tick(4);
      chk_b("mirror_rails_en", 1'b0, rails);
      chk_b("thermal_flag", 1'b1, flags.thermal_shutdown);
      chk_b("mirror_supply_enable", 1'b1, mse);
      fault_cmp.thermal_shutdown = 1'b0;
      wait_led(1'b1);
      read_flags();
      $display("aux and thermal test done");
      fault_cmp.mirror_fault = 1'b1;
      tick(4);
      chk_b("mirror_supply_enable", 1'b0, mse);
      chk_b("mirror_rails_en", 1'b0, rails);
      chk_b("led_driver_en", 1'b0, led);
      fault_cmp.mirror_fault = 1'b0;
      tick(40);
      chk_b("led_driver_en", 1'b0, led);
      read_flags();
      toggle_on();
      wait_led(1'b1);
      $display("mirror fault test done");
      fault_cmp.undervoltage = 1'b1;
      tick(4);
      chk_b("undervoltage_flag", 1'b1, flags.undervoltage);
      chk_b("mirror_supply_enable", 1'b0, mse);
      toggle_on();
      tick(20);
      chk_b("mirror_rails_en", 1'b0, rails);
      chk_b("standby", 1'b1, stby);
      fault_cmp.undervoltage = 1'b0;
      tick(40);
      chk_b("led_driver_en", 1'b0, led);
      read_flags();
      toggle_on();
      wait_led(1'b1);
      $display("lockout test done");
      @(negedge sys_clk) rst = 1'b1;
      tick(2);
      rst = 1'b0;
      tick(1);
      chk_b("mirror_rails_en", 1'b0, rails);
      chk_b("mirror_supply_enable", 1'b1, mse);
      $display("second reset test done");
      conclude();
   end
endmodule : testbench
